//--- src/pspc_defs.svh
// Functional notes
// RULE1: remote switch holds closed at least 25 ms and open at least 50 ms.
// RULE2: remote on/off input acts in local mode and every remote mode.
// RULE3: contact closing edge starts pump, opening edge stops it.
// RULE4: power button always toggles run, even with contacts closed; code toggles only on main screen with mode not held.
// RULE5: after a button stop, remote restart needs contacts open then close.
// RULE6: local/remote modes, local default, mode button toggles, led colour.
// RULE7: local mode strokes at user rate, 1 per hour to 120 per minute.
// RULE8: stopped local pump, hold up+down opens flow-unit menu; power exits.
// RULE9: remote mode, hold power+mode five seconds cycles pacing submode.
// RULE10: display shows divide, multiply or milliamp symbol per submode.
// RULE11: divide mode strokes once per divisor qualified pulses; up/down set it.
// RULE12: running divide mode displays approximate stroke rate.
// RULE13: pulse counts only if at least minimum width; up+down hold edits width.
// RULE14: width screen saves and returns after four seconds without a press.
// RULE15: multiply mode up/down set strokes per qualified pulse.
// RULE16: each pulse loads down-counter; one stroke per half second to zero.
// RULE17: analog mode up/down opens and adjusts zero-rate current point.
// RULE18: power or eight idle seconds moves to maximum-rate current point.
// RULE19: analog maximum rate is 120 per minute or 59 per hour by range.
// RULE20: analog rate interpolates linearly between points, clamped outside.
// RULE21: remote contact is synchronised and debounced before edge detection.
`ifndef PSPC_DEFS_SVH
`define PSPC_DEFS_SVH
`define PSPC_CLK_HZ 125000000
`define PSPC_MS_CYC (`PSPC_CLK_HZ / 1000)
`define PSPC_CONTACT_ON_MIN_MS 25
`define PSPC_CONTACT_OFF_MIN_MS 50
`define PSPC_DEBOUNCE_MS 10
`define PSPC_HOLD_SUB_MS 5000
`define PSPC_HOLD_UD_MS 2000
`define PSPC_IDLE_WIDTH_MS 4000
`define PSPC_IDLE_CAL_MS 8000
`define PSPC_HALF_SEC_MS 500
`define PSPC_FLASH_MS 100
`define PSPC_MINUTE_MS 60000
`define PSPC_HOUR_MS 32'h0036EE80
`define PSPC_RATE_MAX_HI 13'h1C20
`define PSPC_RATE_MAX_LO 13'h003B
`define PSPC_RATE_MIN 13'h0001
`define PSPC_PIN_CONTACT 0
`define PSPC_PIN_PULSE 1
`define PSPC_PIN_POWER 2
`define PSPC_PIN_MODE 3
`define PSPC_PIN_UP 4
`define PSPC_PIN_DOWN 5
`define PSPC_ADDR_CTRL 6'h00
`define PSPC_ADDR_RATE 6'h04
`define PSPC_ADDR_DIV 6'h08
`define PSPC_ADDR_MUL 6'h0C
`define PSPC_ADDR_WIDTH 6'h10
`define PSPC_ADDR_ZERO_PT 6'h14
`define PSPC_ADDR_MAX_PT 6'h18
`define PSPC_ADDR_STATUS 6'h1C
`define PSPC_RST_RATE 13'h0E10
`define PSPC_RST_DIV 8'h01
`define PSPC_RST_MUL 8'h01
`define PSPC_RST_WIDTH 8'h3C
`define PSPC_RST_ZERO_PT 8'h28
`define PSPC_RST_MAX_PT 8'hC8
`endif

//--- src/pspc_pkg.sv
package pspc_pkg;
  typedef enum logic {MODE_LOCAL, MODE_REMOTE} pspc_mode_e;
  typedef enum logic [1:0] {SUB_DIVIDE, SUB_MULTIPLY, SUB_ANALOG} pspc_sub_e;
  typedef enum logic [2:0] {
    SCR_MAIN, SCR_FLOW, SCR_WIDTH, SCR_ZERO_PT, SCR_MAX_PT
  } pspc_scr_e;
  typedef enum logic [1:0] {
    SYM_NONE, SYM_DIVIDE, SYM_MULTIPLY, SYM_MILLIAMP
  } pspc_sym_e;
  typedef struct packed {
    logic read;
    logic write;
    logic [5:0] address;
    logic [31:0] writedata;
  } pspc_avs_req_s;
  typedef struct packed {
    logic power;
    logic mode;
    logic up;
    logic down;
  } pspc_btn_s;
  typedef struct packed {
    pspc_sym_e symbol;
    pspc_scr_e screen;
    logic [1:0] flowUnit;
    logic [15:0] value;
  } pspc_disp_s;
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] prev;
    logic [16:0] msCnt;
    logic msTick;
    logic contactDb;
    logic [5:0] dbCnt;
    logic run;
    pspc_mode_e mode;
    pspc_sub_e sub;
    pspc_scr_e scr;
    logic [1:0] flowUnit;
    logic speedHigh;
    logic [12:0] localRate;
    logic [7:0] divisor;
    logic [7:0] multiplier;
    logic [7:0] pulseWidth;
    logic [7:0] zeroPt;
    logic [7:0] maxPt;
    logic [12:0] holdMs;
    logic [12:0] idleMs;
    logic [7:0] pulseMs;
    logic [7:0] divCnt;
    logic [7:0] downCnt;
    logic [8:0] halfMs;
    logic [31:0] acc;
    logic [15:0] winMs;
    logic [7:0] winStrokes;
    logic [7:0] spm;
    logic [6:0] flashMs;
    logic stroke;
    logic busAck;
    logic [31:0] rdata;
    pspc_disp_s disp;
  } pspc_state_s;
endpackage

//--- src/pspc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pspc_defs.svh"
module pspc_top #(
  parameter int unsigned MS_CYCLES = `PSPC_MS_CYC
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire pspc_pkg::pspc_avs_req_s avsReq,
  output logic [31:0] avsReadData,
  output logic avsWaitrequest,
  input wire logic remoteContact,
  input wire logic pulseIn,
  input wire pspc_pkg::pspc_btn_s buttons,
  input wire logic [7:0] analogIn,
  output logic strokeOut,
  output logic pumpRunning,
  output logic ledGreen,
  output logic ledYellow,
  output pspc_pkg::pspc_disp_s display
);
  import pspc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state and helpers
  pspc_state_s st_reg;
  pspc_state_s st_next;
  logic [5:0] pins;
  logic [5:0] press;
  logic [16:0] msLast;
  logic tick;
  logic closed;
  logic dbDone;
  logic holdUd;
  logic holdPm;
  logic up;
  logic dn;
  logic idleAny;
  logic qual;
  logic [7:0] span;
  logic [12:0] maxRate;
  logic [20:0] anaNum;
  logic [31:0] add;
  logic [31:0] thr;
  logic [32:0] sum;

  function automatic logic [12:0] stepVal(input logic [12:0] v,
      input logic [12:0] lo, input logic [12:0] hi,
      input logic inc, input logic dec);
    if (inc && v < hi) begin
      stepVal = v + 13'h0001;
    end else if (dec && v > lo) begin
      stepVal = v - 13'h0001;
    end else begin
      stepVal = v;
    end
  endfunction

  function automatic logic hitMs(input logic t, input logic [15:0] cnt,
      input int unsigned lim);
    hitMs = t && (cnt == 16'(lim - 1));
  endfunction

  assign pins = {buttons.down, buttons.up, buttons.mode, buttons.power,
                 pulseIn, remoteContact};
  assign msLast = 17'(MS_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.stroke = 1'b0;
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    st_next.prev = st_reg.s2;
    press = st_reg.s2 & ~st_reg.prev;
    tick = st_reg.msTick;
    st_next.msTick = (st_reg.msCnt == msLast);
    st_next.msCnt = st_next.msTick ? 17'h00000 : st_reg.msCnt + 17'h00001;

    // contact debounce and edges
    closed = st_reg.s2[`PSPC_PIN_CONTACT];
    dbDone = tick && closed != st_reg.contactDb
             && st_reg.dbCnt == 6'(`PSPC_DEBOUNCE_MS - 1);
    if (closed == st_reg.contactDb) begin
      st_next.dbCnt = 6'h00; // RULE21
    end else if (tick) begin
      st_next.dbCnt = st_reg.dbCnt + 6'h01;
    end
    if (dbDone) begin
      st_next.contactDb = closed;
      st_next.dbCnt = 6'h00;
      st_next.run = closed; // RULE2 RULE3 RULE5
    end

    // button timing
    holdUd = st_reg.s2[`PSPC_PIN_UP] && st_reg.s2[`PSPC_PIN_DOWN];
    holdPm = st_reg.s2[`PSPC_PIN_POWER] && st_reg.s2[`PSPC_PIN_MODE];
    up = press[`PSPC_PIN_UP] && !st_reg.s2[`PSPC_PIN_DOWN];
    dn = press[`PSPC_PIN_DOWN] && !st_reg.s2[`PSPC_PIN_UP];
    idleAny = |press[5:2];
    if (!(holdUd || holdPm)) begin
      st_next.holdMs = 13'h0000;
    end else if (tick && st_reg.holdMs != 13'h1FFF) begin
      st_next.holdMs = st_reg.holdMs + 13'h0001;
    end
    if (idleAny) begin
      st_next.idleMs = 13'h0000;
    end else if (tick && st_reg.idleMs != 13'h1FFF) begin
      st_next.idleMs = st_reg.idleMs + 13'h0001;
    end

    // screens and buttons
    unique case (st_reg.scr)
      SCR_MAIN: begin
        if (press[`PSPC_PIN_POWER] && !st_reg.s2[`PSPC_PIN_MODE]) begin
          st_next.run = !st_next.run; // RULE4
        end
        if (press[`PSPC_PIN_MODE] && !st_reg.s2[`PSPC_PIN_POWER]) begin
          st_next.mode = (st_reg.mode == MODE_LOCAL) ? MODE_REMOTE
                                                      : MODE_LOCAL; // RULE6
        end
        if (holdPm && st_reg.mode == MODE_REMOTE
            && hitMs(tick, {3'h0, st_reg.holdMs}, `PSPC_HOLD_SUB_MS)) begin
          unique case (st_reg.sub) // RULE9
            SUB_DIVIDE: st_next.sub = SUB_MULTIPLY;
            SUB_MULTIPLY: st_next.sub = SUB_ANALOG;
            SUB_ANALOG: st_next.sub = SUB_DIVIDE;
            default: st_next.sub = SUB_DIVIDE;
          endcase
        end
        if (holdUd && hitMs(tick, {3'h0, st_reg.holdMs},
                            `PSPC_HOLD_UD_MS)) begin
          if (st_reg.mode == MODE_LOCAL && !st_reg.run) begin
            st_next.scr = SCR_FLOW; // RULE8
          end else if (st_reg.mode == MODE_REMOTE
                       && st_reg.sub != SUB_ANALOG) begin
            st_next.scr = SCR_WIDTH; // RULE13
          end
        end
        if (st_reg.mode == MODE_LOCAL) begin
          st_next.localRate = stepVal(st_reg.localRate, `PSPC_RATE_MIN,
                                      `PSPC_RATE_MAX_HI, up, dn); // RULE7
        end else if (st_reg.sub == SUB_DIVIDE) begin
          st_next.divisor = 8'(stepVal({5'h00, st_reg.divisor}, 13'h0001,
                                       13'h00FF, up, dn)); // RULE11
        end else if (st_reg.sub == SUB_MULTIPLY) begin
          st_next.multiplier = 8'(stepVal({5'h00, st_reg.multiplier},
                                          13'h0001, 13'h00FF, up, dn));
        end else if (up || dn) begin
          st_next.scr = SCR_ZERO_PT; // RULE17
        end
      end
      SCR_FLOW: begin
        if (up) begin
          st_next.flowUnit = st_reg.flowUnit + 2'h1; // RULE8
        end else if (dn) begin
          st_next.flowUnit = st_reg.flowUnit - 2'h1;
        end
        if (press[`PSPC_PIN_POWER]) begin
          st_next.scr = SCR_MAIN;
        end
      end
      SCR_WIDTH: begin
        if (!holdUd) begin
          st_next.pulseWidth = 8'(stepVal({5'h00, st_reg.pulseWidth},
                                          13'h0001, 13'h00FF, up, dn));
        end
        if (hitMs(tick, {3'h0, st_reg.idleMs}, `PSPC_IDLE_WIDTH_MS)
            && !idleAny) begin
          st_next.scr = SCR_MAIN; // RULE14
        end
      end
      SCR_ZERO_PT: begin
        st_next.zeroPt = 8'(stepVal({5'h00, st_reg.zeroPt}, 13'h0000,
                                    13'h00FF, up, dn)); // RULE17
        if (press[`PSPC_PIN_POWER] || (!idleAny && hitMs(tick,
            {3'h0, st_reg.idleMs}, `PSPC_IDLE_CAL_MS))) begin
          st_next.scr = SCR_MAX_PT; // RULE18
          st_next.idleMs = 13'h0000;
        end
      end
      SCR_MAX_PT: begin
        st_next.maxPt = 8'(stepVal({5'h00, st_reg.maxPt}, 13'h0000,
                                   13'h00FF, up, dn));
        if (press[`PSPC_PIN_POWER] || (!idleAny && hitMs(tick,
            {3'h0, st_reg.idleMs}, `PSPC_IDLE_CAL_MS))) begin
          st_next.scr = SCR_MAIN;
        end
      end
      default: st_next.scr = SCR_MAIN;
    endcase

    // pulse qualification
    if (!st_reg.s2[`PSPC_PIN_PULSE]) begin
      st_next.pulseMs = 8'h00;
    end else if (tick && st_reg.pulseMs != st_reg.pulseWidth) begin
      st_next.pulseMs = st_reg.pulseMs + 8'h01;
    end
    qual = tick && st_reg.s2[`PSPC_PIN_PULSE]
           && st_reg.pulseMs == st_reg.pulseWidth - 8'h01; // RULE13

    // rate accumulator for local and analog pacing
    span = (st_reg.maxPt > st_reg.zeroPt) ? st_reg.maxPt - st_reg.zeroPt
                                          : 8'h00;
    maxRate = st_reg.speedHigh ? `PSPC_RATE_MAX_HI
                               : `PSPC_RATE_MAX_LO; // RULE19
    if (analogIn <= st_reg.zeroPt || span == 8'h00) begin
      anaNum = 21'h000000; // RULE20
    end else if (analogIn >= st_reg.maxPt) begin
      anaNum = 21'(span) * 21'(maxRate);
    end else begin
      anaNum = 21'(analogIn - st_reg.zeroPt) * 21'(maxRate);
    end
    if (st_reg.mode == MODE_LOCAL) begin
      add = {19'h00000, st_reg.localRate};
      thr = `PSPC_HOUR_MS;
    end else begin
      add = {11'h000, anaNum};
      thr = 32'(`PSPC_HOUR_MS * span);
    end
    sum = {1'b0, st_reg.acc} + {1'b0, add};
    if (!st_reg.run) begin
      st_next.acc = 32'h00000000;
      st_next.divCnt = 8'h00;
      st_next.downCnt = 8'h00;
    end else if (st_reg.mode == MODE_LOCAL || st_reg.sub == SUB_ANALOG) begin
      if (tick && thr != 32'h00000000) begin
        if (sum >= {1'b0, thr}) begin
          st_next.acc = 32'(sum - {1'b0, thr});
          st_next.stroke = 1'b1; // RULE7 RULE20
        end else begin
          st_next.acc = sum[31:0];
        end
      end
    end else if (st_reg.sub == SUB_DIVIDE) begin
      if (qual) begin
        if (st_reg.divCnt + 8'h01 >= st_reg.divisor) begin
          st_next.divCnt = 8'h00;
          st_next.stroke = 1'b1; // RULE11
        end else begin
          st_next.divCnt = st_reg.divCnt + 8'h01;
        end
      end
    end else if (qual) begin
      st_next.downCnt = st_reg.multiplier; // RULE15 RULE16
      st_next.halfMs = 9'h000;
    end else if (tick && st_reg.downCnt != 8'h00) begin
      if (st_reg.halfMs == 9'(`PSPC_HALF_SEC_MS - 1)) begin
        st_next.halfMs = 9'h000;
        st_next.downCnt = st_reg.downCnt - 8'h01;
        st_next.stroke = 1'b1; // RULE16
      end else begin
        st_next.halfMs = st_reg.halfMs + 9'h001;
      end
    end

    // strokes per minute window and indicator flash
    if (tick) begin
      if (st_reg.winMs == 16'(`PSPC_MINUTE_MS - 1)) begin
        st_next.winMs = 16'h0000;
        st_next.spm = st_reg.winStrokes; // RULE12
        st_next.winStrokes = 8'h00;
      end else begin
        st_next.winMs = st_reg.winMs + 16'h0001;
      end
    end
    if (st_next.stroke) begin
      st_next.winStrokes = st_next.winStrokes + 8'h01;
      st_next.flashMs = 7'(`PSPC_FLASH_MS);
    end else if (tick && st_reg.flashMs != 7'h00) begin
      st_next.flashMs = st_reg.flashMs - 7'h01;
    end

    // register bus
    st_next.busAck = (avsReq.read || avsReq.write) && !st_reg.busAck;
    if (st_next.busAck) begin
      unique case (avsReq.address)
        `PSPC_ADDR_CTRL: st_next.rdata = {31'h0, st_reg.speedHigh};
        `PSPC_ADDR_RATE: st_next.rdata = {19'h0, st_reg.localRate};
        `PSPC_ADDR_DIV: st_next.rdata = {24'h0, st_reg.divisor};
        `PSPC_ADDR_MUL: st_next.rdata = {24'h0, st_reg.multiplier};
        `PSPC_ADDR_WIDTH: st_next.rdata = {24'h0, st_reg.pulseWidth};
        `PSPC_ADDR_ZERO_PT: st_next.rdata = {24'h0, st_reg.zeroPt};
        `PSPC_ADDR_MAX_PT: st_next.rdata = {24'h0, st_reg.maxPt};
        `PSPC_ADDR_STATUS: st_next.rdata = {st_reg.disp.value[14:0],
            st_reg.downCnt, st_reg.flowUnit, st_reg.scr, st_reg.sub,
            st_reg.mode, st_reg.run};
        default: st_next.rdata = 32'h00000000;
      endcase
    end
    if (st_reg.busAck && avsReq.write) begin
      unique case (avsReq.address)
        `PSPC_ADDR_CTRL: st_next.speedHigh = avsReq.writedata[0];
        `PSPC_ADDR_RATE: st_next.localRate =
            (avsReq.writedata > {19'h0, `PSPC_RATE_MAX_HI})
            ? `PSPC_RATE_MAX_HI : (avsReq.writedata == 32'h0)
            ? `PSPC_RATE_MIN : avsReq.writedata[12:0]; // RULE7
        `PSPC_ADDR_DIV: st_next.divisor = avsReq.writedata[7:0];
        `PSPC_ADDR_MUL: st_next.multiplier = avsReq.writedata[7:0];
        `PSPC_ADDR_WIDTH: st_next.pulseWidth = avsReq.writedata[7:0];
        `PSPC_ADDR_ZERO_PT: st_next.zeroPt = avsReq.writedata[7:0];
        `PSPC_ADDR_MAX_PT: st_next.maxPt = avsReq.writedata[7:0];
        default: st_next.speedHigh = st_next.speedHigh;
      endcase
    end

    // display
    st_next.disp.screen = st_next.scr;
    st_next.disp.flowUnit = st_next.flowUnit;
    if (st_next.mode == MODE_LOCAL) begin
      st_next.disp.symbol = SYM_NONE;
    end else if (st_next.sub == SUB_DIVIDE) begin
      st_next.disp.symbol = SYM_DIVIDE; // RULE10
    end else if (st_next.sub == SUB_MULTIPLY) begin
      st_next.disp.symbol = SYM_MULTIPLY;
    end else begin
      st_next.disp.symbol = SYM_MILLIAMP;
    end
    unique case (st_next.scr)
      SCR_FLOW: st_next.disp.value = {14'h0, st_next.flowUnit};
      SCR_WIDTH: st_next.disp.value = {8'h0, st_next.pulseWidth};
      SCR_ZERO_PT: st_next.disp.value = {8'h0, st_next.zeroPt};
      SCR_MAX_PT: st_next.disp.value = {8'h0, st_next.maxPt};
      default: begin
        if (st_next.mode == MODE_LOCAL) begin
          st_next.disp.value = {3'h0, st_next.localRate};
        end else if (st_next.sub == SUB_DIVIDE) begin
          st_next.disp.value = st_next.run ? {8'h0, st_next.spm}
                                           : {8'h0, st_next.divisor};
        end else if (st_next.sub == SUB_MULTIPLY) begin
          st_next.disp.value = st_next.run ? {8'h0, st_next.downCnt}
                                           : {8'h0, st_next.multiplier};
        end else begin
          st_next.disp.value = {8'h0, analogIn};
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_reg <= '0;
      st_reg.mode <= MODE_LOCAL;
      st_reg.sub <= SUB_DIVIDE;
      st_reg.scr <= SCR_MAIN;
      st_reg.speedHigh <= 1'b1;
      st_reg.localRate <= `PSPC_RST_RATE;
      st_reg.divisor <= `PSPC_RST_DIV;
      st_reg.multiplier <= `PSPC_RST_MUL;
      st_reg.pulseWidth <= `PSPC_RST_WIDTH;
      st_reg.zeroPt <= `PSPC_RST_ZERO_PT;
      st_reg.maxPt <= `PSPC_RST_MAX_PT;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign avsReadData = st_reg.rdata;
  assign avsWaitrequest = (avsReq.read || avsReq.write) && !st_reg.busAck;
  assign strokeOut = st_reg.stroke;
  assign pumpRunning = st_reg.run;
  assign ledGreen = st_reg.flashMs != 7'h00 && st_reg.mode == MODE_LOCAL;
  assign ledYellow = st_reg.flashMs != 7'h00 && st_reg.mode == MODE_REMOTE;
  assign display = st_reg.disp;
endmodule
`default_nettype wire

//--- test/pspc_top_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module pspc_top_assertions #(
  parameter int unsigned MS_CYCLES = 125000
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire pspc_pkg::pspc_avs_req_s avsReq,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitrequest,
  input wire logic remoteContact,
  input wire logic pulseIn,
  input wire pspc_pkg::pspc_btn_s buttons,
  input wire logic [7:0] analogIn,
  input wire logic strokeOut,
  input wire logic pumpRunning,
  input wire logic ledGreen,
  input wire logic ledYellow,
  input wire pspc_pkg::pspc_disp_s display
);
  import pspc_pkg::*;
  localparam int DB = 10 * MS_CYCLES + 8;
  localparam int HALF = 500 * MS_CYCLES - 2;
  logic [31:0] closeCnt, openCnt, gapCnt;
  function automatic logic [31:0] sat(input logic [31:0] v);
    return (v == '1) ? v : v + 32'h1;
  endfunction
  // cycles with contact steady, cycles since last stroke
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      closeCnt <= '0;
      openCnt <= '1;
      gapCnt <= '1;
    end else begin
      closeCnt <= remoteContact ? sat(closeCnt) : '0;
      openCnt <= remoteContact ? '0 : sat(openCnt);
      gapCnt <= strokeOut ? 32'h1 : sat(gapCnt);
    end
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  sequence sBusReq;
    (avsReq.read || avsReq.write) && avsWaitrequest;
  endsequence
  sequence sPowerPress;
    $rose(buttons.power) && !buttons.mode && display.screen == SCR_MAIN;
  endsequence
  a_bus_answer: assert property (sBusReq |=> !avsWaitrequest)
    else $error("bus not answered");
  a_unmapped_zero: assert property (avsReq.read && !avsWaitrequest &&
    avsReq.address > 6'h1C |-> avsReadData == 32'h0)
    else $error("unmapped read not zero");
  a_power_toggles: assert property (
    sPowerPress |-> ##[1:6] $changed(pumpRunning))
    else $error("power press ignored");
  a_close_starts: assert property (
    closeCnt == DB |-> pumpRunning) else $error("close did not start");
  a_open_stops: assert property (
    openCnt == DB |-> !pumpRunning) else $error("open did not stop");
  a_stroke_run: assert property (
    strokeOut |-> pumpRunning) else $error("stroke while stopped");
  a_stroke_single: assert property (
    strokeOut |=> !strokeOut) else $error("stroke longer than a cycle");
  a_led_flash: assert property (
    strokeOut |=> (ledGreen || ledYellow) [*4]) else $error("no flash");
  a_green_local: assert property (
    ledGreen |-> !ledYellow && display.symbol == SYM_NONE)
    else $error("green outside local");
  a_yellow_remote: assert property (
    ledYellow |-> display.symbol != SYM_NONE)
    else $error("yellow without symbol");
  a_mult_spacing: assert property (
    strokeOut && display.symbol == SYM_MULTIPLY |-> gapCnt >= HALF)
    else $error("multiply strokes too close");
endmodule
bind pspc_top pspc_top_assertions #(.MS_CYCLES(MS_CYCLES)) i_chk (
  .mclk(mclk), .resetn(resetn), .avsReq(avsReq),
  .avsReadData(avsReadData), .avsWaitrequest(avsWaitrequest),
  .remoteContact(remoteContact), .pulseIn(pulseIn), .buttons(buttons),
  .analogIn(analogIn), .strokeOut(strokeOut), .pumpRunning(pumpRunning),
  .ledGreen(ledGreen), .ledYellow(ledYellow), .display(display));
`default_nettype wire

//--- test/pspc_ext_source.sv
`timescale 1ns/100ps
`default_nettype none
module pspc_ext_source #(
  parameter int unsigned MS_CYCLES = 2
) (
  input wire logic mclk,
  output logic remoteContact,
  output logic pulseIn
);
  initial begin
    remoteContact = 1'b0;
    pulseIn = 1'b0;
  end
  task automatic wait_ms(input int n);
    repeat (n * MS_CYCLES) @(posedge mclk);
  endtask
  // contact change, then minimum dwell
  task automatic set_contact(input logic closed);
    @(posedge mclk) remoteContact <= closed;
    wait_ms(closed ? 25 : 50);
  endtask
  // bounce shorter than debounce
  task automatic bounce(input int cycles);
    @(posedge mclk) remoteContact <= ~remoteContact;
    repeat (cycles) @(posedge mclk);
    remoteContact <= ~remoteContact;
  endtask
  task automatic pulse(input int widthMs);
    @(posedge mclk) pulseIn <= 1'b1;
    wait_ms(widthMs);
    pulseIn <= 1'b0;
    wait_ms(50);
  endtask
endmodule
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  import pspc_pkg::*;
  localparam int unsigned MS = 2;
  localparam logic [3:0] B_POW = 4'h8;
  localparam logic [3:0] B_MODE = 4'h4;
  localparam logic [3:0] B_UP = 4'h2;
  localparam logic [3:0] B_UD = 4'h3;
  logic mclk, resetn, avsWaitrequest, remoteContact, pulseIn;
  logic strokeOut, pumpRunning, ledGreen, ledYellow;
  logic [31:0] avsReadData, q;
  logic [7:0] analogIn;
  pspc_avs_req_s avsReq;
  pspc_btn_s buttons;
  pspc_disp_s display;
  int num_errors, n_compared, cyc, strokes, lastCyc, gap, base;
  logic [5:0] addrs [8] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14,
    6'h18, 6'h20};
  logic [31:0] dflt [8] = '{32'h1, 32'hE10, 32'h1, 32'h1, 32'h3C, 32'h28,
    32'hC8, 32'h0};
  pspc_top #(.MS_CYCLES(MS)) i_dut (.mclk(mclk), .resetn(resetn),
    .avsReq(avsReq), .avsReadData(avsReadData),
    .avsWaitrequest(avsWaitrequest), .remoteContact(remoteContact),
    .pulseIn(pulseIn), .buttons(buttons), .analogIn(analogIn),
    .strokeOut(strokeOut), .pumpRunning(pumpRunning),
    .ledGreen(ledGreen), .ledYellow(ledYellow), .display(display));
  pspc_ext_source #(.MS_CYCLES(MS)) i_src (.mclk(mclk),
    .remoteContact(remoteContact), .pulseIn(pulseIn));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // stroke log and hang guard
  always @(posedge mclk) begin
    cyc++;
    if (strokeOut === 1'b1) begin
      strokes++;
      gap = cyc - lastCyc;
      lastCyc = cyc;
    end
    if (cyc == 80000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_ms(input int n);
    repeat (n * MS) @(posedge mclk);
  endtask
  task automatic bus(input logic wr, input logic [5:0] a,
      input logic [31:0] d, output logic [31:0] r);
    @(posedge mclk);
    avsReq <= '{read: ~wr, write: wr, address: a, writedata: d};
    do @(posedge mclk); while (avsWaitrequest !== 1'b0);
    r = avsReadData;
    avsReq <= '0;
  endtask
  task automatic wrrd(input logic [5:0] a, input logic [31:0] d,
      input logic [31:0] exp);
    bus(1'b1, a, d, q);
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask
  task automatic press(input logic [3:0] b, input int ms);
    @(posedge mclk) buttons <= pspc_btn_s'(b);
    wait_ms(ms);
    buttons <= '0;
    wait_ms(20);
  endtask
  task automatic wait_strokes(input int n);
    int s0;
    s0 = strokes;
    while (strokes < s0 + n) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    avsReq = '0;
    buttons = '0;
    analogIn = 8'h00;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    bus(1'b1, 6'h20, 32'hFFFFFFFF, q);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, addrs[i], 32'h0, q);
      check(q, dflt[i]);
    end
    wrrd(6'h04, 32'h1FFF, 32'h1C20);
    wrrd(6'h04, 32'h0, 32'h1);
    wrrd(6'h04, 32'h1C20, 32'h1C20);
    press(B_POW, 20);
    check(32'(pumpRunning), 32'h1);
    wait_strokes(2);
    check(gap, 500 * MS);
    check(32'(ledGreen), 32'h1);
    press(B_POW, 20);
    check(32'(pumpRunning), 32'h0);
    press(B_UD, 2100);
    check(32'(display.screen), 32'(SCR_FLOW));
    press(B_UP, 20);
    check(32'(display.flowUnit), 32'h1);
    press(B_POW, 20);
    check(32'(display.screen), 32'(SCR_MAIN));
    check(32'(pumpRunning), 32'h0);
    i_src.bounce(5);
    wait_ms(20);
    check(32'(pumpRunning), 32'h0);
    i_src.set_contact(1'b1);
    check(32'(pumpRunning), 32'h1);
    press(B_POW, 20);
    check(32'(pumpRunning), 32'h0);
    wait_ms(30);
    check(32'(pumpRunning), 32'h0);
    i_src.set_contact(1'b0);
    i_src.set_contact(1'b1);
    check(32'(pumpRunning), 32'h1);
    i_src.set_contact(1'b0);
    check(32'(pumpRunning), 32'h0);
    press(B_MODE, 20);
    check(32'(display.symbol), 32'(SYM_DIVIDE));
    i_src.set_contact(1'b1);
    check(32'(pumpRunning), 32'h1);
    i_src.set_contact(1'b0);
    check(32'(pumpRunning), 32'h0);
    wrrd(6'h08, 32'h2, 32'h2);
    press(B_POW, 20);
    base = strokes;
    i_src.pulse(30);
    i_src.pulse(70);
    check(strokes - base, 0);
    i_src.pulse(70);
    check(strokes - base, 1);
    check(32'(display.value), 32'h0);
    press(B_POW, 20);
    press(B_UD, 2100);
    check(32'(display.screen), 32'(SCR_WIDTH));
    press(B_UP, 20);
    wait_ms(4100);
    check(32'(display.screen), 32'(SCR_MAIN));
    bus(1'b0, 6'h10, 32'h0, q);
    check(q, 32'h3D);
    press(B_POW | B_MODE, 5100);
    check(32'(display.symbol), 32'(SYM_MULTIPLY));
    check(32'(pumpRunning), 32'h0);
    bus(1'b1, 6'h0C, 32'h2, q);
    press(B_UP, 20);
    bus(1'b0, 6'h0C, 32'h0, q);
    check(q, 32'h3);
    press(B_POW, 20);
    base = strokes;
    i_src.pulse(70);
    check(32'(display.value), 32'h3);
    wait_ms(1700);
    check(strokes - base, 3);
    check(gap, 500 * MS);
    press(B_POW, 20);
    press(B_POW | B_MODE, 5100);
    check(32'(display.symbol), 32'(SYM_MILLIAMP));
    press(B_UP, 20);
    check(32'(display.screen), 32'(SCR_ZERO_PT));
    press(B_POW, 20);
    check(32'(display.screen), 32'(SCR_MAX_PT));
    press(B_POW, 20);
    check(32'(display.screen), 32'(SCR_MAIN));
    analogIn <= 8'hC8;
    press(B_POW, 20);
    wait_strokes(2);
    check(gap, 500 * MS);
    analogIn <= 8'h78;
    wait_strokes(2);
    check(gap, 1000 * MS);
    wrrd(6'h00, 32'h0, 32'h0);
    base = strokes;
    wait_ms(1200);
    check(strokes - base, 0);
    press(B_POW, 20);
    press(B_POW | B_MODE, 5100);
    check(32'(display.symbol), 32'(SYM_DIVIDE));
    tally_and_finish();
  end
endmodule
`default_nettype wire
